// file: sdram_pkg.sv
// Purpose: Shared constants for the synchronous DRAM module model
// Assumes: One rising-edge clock for commands, data and masks
// Notes: Presence-detect table is a constant; its checksum is derived
package sdram_pkg;
   localparam int DATA_WIDTH = 64;
   localparam int LANES = 8;
   localparam int BYTE_WIDTH = 8;
   localparam int ADDR_WIDTH = 12;
   localparam int BANK_WIDTH = 2;
   localparam int INDEX_WIDTH = 4;
   localparam int STORE_DEPTH = 16;
   localparam int BUFFER_DEPTH = 32;
   localparam int ENTRY_WIDTH = INDEX_WIDTH + DATA_WIDTH + LANES;
   localparam int PRESENCE_LAST_SUMMED = 62;

   // ****************************************
   // Commands as {select, row, column, write}, all active low
   // ****************************************
   localparam logic [3:0] CMD_MODE_SET = 4'h0;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_PRECHARGE = 4'h2;
   localparam logic [3:0] CMD_ACTIVATE = 4'h3;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_BURST_STOP = 4'h6;

   // ****************************************
   // Mode register fields
   // ****************************************
   localparam int MODE_LATENCY_HI = 6;
   localparam int MODE_LATENCY_LO = 4;
   localparam int MODE_BURST_HI = 2;
   localparam logic [2:0] LATENCY_TWO = 3'h2;
   localparam logic [2:0] LATENCY_THREE = 3'h3;
   localparam logic [2:0] RESET_LATENCY = 3'h3;
   localparam logic [2:0] RESET_BURST = 3'h0;
   localparam logic [2:0] BURST_PAGE = 3'h7;
   localparam logic [8:0] BURST_SINGLE = 9'h001;
   localparam logic [8:0] PAGE_LENGTH = 9'h000;

   localparam logic [7:0] PRESENCE_CHECKSUM_OFFSET = 8'h3f;

   function automatic logic [8:0] burst_length(input logic [2:0] code);
      if (code == BURST_PAGE) begin
         burst_length = PAGE_LENGTH;
      end else if (code[2]) begin
         burst_length = BURST_SINGLE;
      end else begin
         burst_length = BURST_SINGLE << code[1:0];
      end
   endfunction

   function automatic logic [7:0] presence_byte(input logic [7:0] index);
      case (index)
         8'h00: presence_byte = 8'h80;
         8'h01: presence_byte = 8'h08;
         8'h02: presence_byte = 8'h04;
         8'h03: presence_byte = 8'h0c;
         8'h04: presence_byte = 8'h09;
         8'h05: presence_byte = 8'h01;
         8'h06: presence_byte = 8'h40;
         8'h08: presence_byte = 8'h01;
         8'h09: presence_byte = 8'ha0;
         8'h0a: presence_byte = 8'h85;
         8'h0c: presence_byte = 8'h80;
         8'h0d: presence_byte = 8'h08;
         8'h0f: presence_byte = 8'h01;
         8'h10: presence_byte = 8'h8f;
         8'h11: presence_byte = 8'h04;
         8'h12: presence_byte = 8'h06;
         8'h13: presence_byte = 8'h01;
         8'h14: presence_byte = 8'h01;
         8'h16: presence_byte = 8'h0e;
         8'h17: presence_byte = 8'hf0;
         8'h18: presence_byte = 8'h90;
         8'h1b: presence_byte = 8'h1e;
         8'h1c: presence_byte = 8'h14;
         8'h1d: presence_byte = 8'h1e;
         8'h1e: presence_byte = 8'h3c;
         8'h1f: presence_byte = 8'h10;
         8'h3e: presence_byte = 8'h01;
         default: presence_byte = 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] presence_sum();
      logic [7:0] sum;
      sum = 8'h00;
      for (int i = 0; i <= PRESENCE_LAST_SUMMED; i++) begin
         sum = sum + presence_byte(8'(i));
      end
      presence_sum = sum;
   endfunction

   localparam logic [7:0] PRESENCE_CHECKSUM = presence_sum();
endpackage

// file: sdram_buffer_if.sv
// Purpose: Valid/ready carrier between the write path and its buffer
// Assumes: Both sides on the same clock
// Notes: Transfer on any rising edge where valid and ready are both high
`timescale 1ns/10ps
interface sdram_buffer_if #(parameter int WIDTH = 8);
   logic pushValid;
   logic pushReady;
   logic [WIDTH-1:0] pushData;
   logic popValid;
   logic popReady;
   logic [WIDTH-1:0] popData;
   modport store(input pushValid, pushData, popReady,
                 output pushReady, popValid, popData);
   modport client(output pushValid, pushData, popReady,
                  input pushReady, popValid, popData);
endinterface

// file: sdram_write_buffer.sv
// Purpose: First-in first-out buffer of flip-flops
// Assumes: Width and depth set by the instantiating module
// Notes: Depth must be a power of two
`timescale 1ns/10ps
module sdram_write_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input wire logic clock,
   input wire logic arst_n,
   sdram_buffer_if.store bus
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] entries [DEPTH];
   logic [PW:0] writePtr;
   logic [PW:0] readPtr;
   logic full;
   logic empty;

   assign full = (writePtr[PW] != readPtr[PW]) &&
                 (writePtr[PW-1:0] == readPtr[PW-1:0]);
   assign empty = writePtr == readPtr;
   assign bus.pushReady = !full;
   assign bus.popValid = !empty;
   assign bus.popData = entries[readPtr[PW-1:0]];

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         writePtr <= '0;
      end else if (bus.pushValid && !full) begin
         writePtr <= writePtr + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         readPtr <= '0;
      end else if (bus.popReady && !empty) begin
         readPtr <= readPtr + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (bus.pushValid && !full) begin
         entries[writePtr[PW-1:0]] <= bus.pushData;
      end
   end
endmodule

// file: sdram_module_device.sv
// Purpose: Command, latency and mask behaviour of a 64-bit DRAM module
// Assumes: Controller meets all spacing minimums; one rank, one clock
// Notes: Storage is a small column window, bank and row are not decoded
// Notes on behaviour
// - Checksum byte equals low eight bits of sum of bytes 0..62.
// - Dropping clock enable suspends internal clock one cycle later.
// - Mask during read floats that byte lane two cycles later.
// - Mask during write blocks the byte sampled that same cycle.
// - Burst stop ends read output after latency-many cycles.
// - Column commands may follow each other every cycle.
`timescale 1ns/10ps
module sdram_module_device (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic cke,
   input wire logic chipSelect_n,
   input wire logic rowStrobe_n,
   input wire logic columnStrobe_n,
   input wire logic writeEnable_n,
   input wire logic [sdram_pkg::ADDR_WIDTH-1:0] address,
   input wire logic [sdram_pkg::BANK_WIDTH-1:0] bankSelect,
   input wire logic [sdram_pkg::LANES-1:0] byteLaneMask,
   input wire logic [sdram_pkg::DATA_WIDTH-1:0] dqIn,
   output logic [sdram_pkg::DATA_WIDTH-1:0] dqOut,
   output logic [sdram_pkg::LANES-1:0] dqOe,
   output logic writeBufferReady,
   input wire logic [7:0] presenceIndex,
   output logic [7:0] presenceByte
);
   localparam int IW = sdram_pkg::INDEX_WIDTH;
   localparam int BW = sdram_pkg::BYTE_WIDTH;
   localparam int DW = sdram_pkg::DATA_WIDTH;
   localparam int LN = sdram_pkg::LANES;

   logic ckeQ;
   logic [3:0] command;
   logic cmdRead;
   logic cmdWrite;
   logic cmdStop;
   logic cmdPrecharge;
   logic cmdModeSet;
   logic breakBurst;
   logic [2:0] columnReadLatency;
   logic [2:0] burstCode;
   logic [8:0] burstLen;
   logic pageMode;
   logic readActive;
   logic [IW-1:0] readCol;
   logic [8:0] readLeft;
   logic writeActive;
   logic [IW-1:0] writeCol;
   logic [8:0] writeLeft;
   logic writeBeat;
   logic [DW-1:0] store [sdram_pkg::STORE_DEPTH];
   logic [DW-1:0] readWord;
   logic stageValid;
   logic [DW-1:0] stageData;
   logic outValid;
   logic [LN-1:0] maskQ;
   logic [LN-1:0] maskQQ;
   logic [IW-1:0] popIndex;
   logic [DW-1:0] popWord;
   logic [LN-1:0] popMask;

   sdram_buffer_if #(.WIDTH(sdram_pkg::ENTRY_WIDTH)) bufferBus ();

   sdram_write_buffer #(
      .WIDTH(sdram_pkg::ENTRY_WIDTH),
      .DEPTH(sdram_pkg::BUFFER_DEPTH)
   ) writeBuffer (
      .clock(clock),
      .arst_n(arst_n),
      .bus(bufferBus.store)
   );

   // ****************************************
   // Clock gating and command decode
   // ****************************************
   // one-cycle gate delay
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ckeQ <= 1'b0;
      end else begin
         ckeQ <= cke;
      end
   end

   assign command = {chipSelect_n, rowStrobe_n, columnStrobe_n, writeEnable_n};
   assign cmdRead = ckeQ && command == sdram_pkg::CMD_READ;
   assign cmdWrite = ckeQ && command == sdram_pkg::CMD_WRITE;
   assign cmdStop = ckeQ && command == sdram_pkg::CMD_BURST_STOP;
   assign cmdPrecharge = ckeQ && command == sdram_pkg::CMD_PRECHARGE;
   assign cmdModeSet = ckeQ && command == sdram_pkg::CMD_MODE_SET;
   assign breakBurst = cmdRead || cmdWrite || cmdStop || cmdPrecharge;
   assign burstLen = sdram_pkg::burst_length(burstCode);
   assign pageMode = burstCode == sdram_pkg::BURST_PAGE;

   // Unsupported latency codes fall back to three, the safe setting
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         columnReadLatency <= sdram_pkg::RESET_LATENCY;
         burstCode <= sdram_pkg::RESET_BURST;
      end else if (cmdModeSet) begin
         columnReadLatency <= (address[sdram_pkg::MODE_LATENCY_HI:
            sdram_pkg::MODE_LATENCY_LO] == sdram_pkg::LATENCY_TWO) ?
            sdram_pkg::LATENCY_TWO : sdram_pkg::LATENCY_THREE;
         burstCode <= address[sdram_pkg::MODE_BURST_HI:0];
      end
   end

   // ****************************************
   // Read burst engine
   // ****************************************
   // stop cuts burst
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         readActive <= 1'b0;
         readCol <= '0;
         readLeft <= '0;
      end else if (cmdRead) begin
         readActive <= 1'b1;
         readCol <= address[IW-1:0];
         readLeft <= burstLen;
      end else if (breakBurst) begin
         readActive <= 1'b0;
      end else if (ckeQ && readActive) begin
         readCol <= readCol + 1'b1;
         if (!pageMode) begin
            readLeft <= readLeft - 1'b1;
            if (readLeft == sdram_pkg::BURST_SINGLE) begin
               readActive <= 1'b0;
            end
         end
      end
   end

   assign readWord = store[readCol];

   // Stage feeds latency three; latency two bypasses it
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stageValid <= 1'b0;
         stageData <= '0;
         outValid <= 1'b0;
         dqOut <= '0;
      end else if (ckeQ) begin
         stageValid <= readActive;
         stageData <= readWord;
         if (columnReadLatency == sdram_pkg::LATENCY_TWO) begin
            outValid <= readActive;
            dqOut <= readWord;
         end else begin
            outValid <= stageValid;
            dqOut <= stageData;
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         maskQ <= '0;
         maskQQ <= '0;
      end else if (ckeQ) begin
         maskQ <= byteLaneMask;
         maskQQ <= maskQ;
      end
   end

   for (genvar g = 0; g < LN; g++) begin : g_lane
      assign dqOe[g] = outValid && !maskQQ[g];
   end

   // ****************************************
   // Write burst engine
   // ****************************************
   // first beat with the command
   assign writeBeat = cmdWrite || (ckeQ && writeActive && !breakBurst);

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         writeActive <= 1'b0;
         writeCol <= '0;
         writeLeft <= '0;
      end else if (cmdWrite) begin
         writeActive <= pageMode || burstLen != sdram_pkg::BURST_SINGLE;
         writeCol <= address[IW-1:0] + 1'b1;
         writeLeft <= burstLen - 1'b1;
      end else if (breakBurst) begin
         writeActive <= 1'b0;
      end else if (writeBeat) begin
         writeCol <= writeCol + 1'b1;
         if (!pageMode) begin
            writeLeft <= writeLeft - 1'b1;
            if (writeLeft == sdram_pkg::BURST_SINGLE) begin
               writeActive <= 1'b0;
            end
         end
      end
   end

   assign bufferBus.pushValid = writeBeat;
   assign bufferBus.pushData = {cmdWrite ? address[IW-1:0] : writeCol,
                                dqIn, byteLaneMask};
   assign writeBufferReady = bufferBus.pushReady;

   // Single storage port: drain yields to read beats
   assign bufferBus.popReady = !readActive;
   assign {popIndex, popWord, popMask} = bufferBus.popData;

   always_ff @(posedge clock) begin
      if (bufferBus.popValid && bufferBus.popReady) begin
         for (int l = 0; l < LN; l++) begin
            if (!popMask[l]) begin
               store[popIndex][l*BW +: BW] <= popWord[l*BW +: BW];
            end
         end
      end
   end

   // ****************************************
   // Presence-detect read port
   // ****************************************
   // checksum over bytes 0..62
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         presenceByte <= 8'h00;
      end else if (presenceIndex == sdram_pkg::PRESENCE_CHECKSUM_OFFSET) begin
         presenceByte <= sdram_pkg::PRESENCE_CHECKSUM;
      end else begin
         presenceByte <= sdram_pkg::presence_byte(presenceIndex);
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   property p_checksum;
      presenceIndex == sdram_pkg::PRESENCE_CHECKSUM_OFFSET |=>
         presenceByte == sdram_pkg::PRESENCE_CHECKSUM;
   endproperty
   a_checksum: assert property (p_checksum)
      else $error("checksum byte wrong");

   property p_clock_gate;
      !cke |-> ##2 ($stable(readCol) && $stable(outValid) &&
                    $stable(maskQQ));
   endproperty
   a_clock_gate: assert property (p_clock_gate)
      else $error("state moved while clock suspended");

   property p_mask_hiz;
      (ckeQ && byteLaneMask[0]) ##1 ckeQ |=> !dqOe[0];
   endproperty
   a_mask_hiz: assert property (p_mask_hiz)
      else $error("masked lane still driven");

   property p_write_mask;
      cmdWrite |-> bufferBus.pushValid &&
         bufferBus.pushData[LN-1:0] == byteLaneMask &&
         bufferBus.pushData[DW+LN-1:LN] == dqIn;
   endproperty
   a_write_mask: assert property (p_write_mask)
      else $error("write beat or mask not taken with command");

   property p_stop_three;
      (cmdStop && columnReadLatency == sdram_pkg::LATENCY_THREE)
         ##1 ckeQ [*2] |=> !(|dqOe);
   endproperty
   a_stop_three: assert property (p_stop_three)
      else $error("output driven three cycles after stop");

   property p_stop_two;
      (cmdStop && columnReadLatency == sdram_pkg::LATENCY_TWO)
         ##1 ckeQ |=> !(|dqOe);
   endproperty
   a_stop_two: assert property (p_stop_two)
      else $error("output driven two cycles after stop");

   property p_precharge_hiz;
      (cmdPrecharge && columnReadLatency == sdram_pkg::LATENCY_THREE)
         ##1 ckeQ [*2] |=> !(|dqOe);
   endproperty
   a_precharge_hiz: assert property (p_precharge_hiz)
      else $error("output driven after precharge");

   property p_precharge_two;
      (cmdPrecharge && columnReadLatency == sdram_pkg::LATENCY_TWO)
         ##1 ckeQ |=> !(|dqOe);
   endproperty
   a_precharge_two: assert property (p_precharge_two)
      else $error("output driven two cycles after precharge");

   property p_back_to_back;
      cmdRead |=> readActive && readCol == $past(address[IW-1:0]);
   endproperty
   a_back_to_back: assert property (p_back_to_back)
      else $error("read command not accepted");

   c_read_burst: cover property (cmdRead ##1 (ckeQ && readActive) [*3]);
   c_stop: cover property (cmdStop && readActive);
   c_back_to_back: cover property (cmdRead ##1 cmdRead);
   c_buffer_full: cover property (writeBeat && !bufferBus.pushReady);
endmodule

// file: sdram_host_model.sv
// Purpose: Lawful memory controller driving the module's command pins
// Assumes: Every task is entered just after a rising clock edge
// Notes: Spacings are rounded up to whole cycles of the bench clock
`timescale 1ns/10ps
module sdram_host_model (
   input wire logic clock,
   output logic cke,
   output logic [3:0] command,
   output logic [11:0] address,
   output logic [1:0] bankSelect,
   output logic [7:0] byteLaneMask,
   output logic [63:0] dqIn
);
   localparam int PERIOD_NS = 20;

   initial begin
      cke = 1'b0;
      command = 4'hf;
      address = 12'h000;
      bankSelect = 2'h0;
      byteLaneMask = 8'h00;
      dqIn = 64'h0;
   end

   function automatic int cyc(input int ns);
      return (ns + PERIOD_NS - 1) / PERIOD_NS;
   endfunction

   // Pins change just after an edge and hold through the next one
   task automatic issue(input logic [3:0] c, input logic [11:0] a,
         input logic [7:0] m, input logic [63:0] d, input logic en);
      command = c;
      address = a;
      bankSelect = a[11:10];
      byteLaneMask = m;
      dqIn = d;
      cke = en;
      @(posedge clock);
      #1;
   endtask

   // Released data lines toggle rather than hold the last value
   // Address and bank wander while idle; no command may use them
   task automatic idle(input int n);
      repeat (n) issue(4'hf, 12'($urandom), 8'h00, ~dqIn, 1'b1);
   endtask

   task automatic open_row(input logic [1:0] b);
      issue(sdram_pkg::CMD_ACTIVATE, {b, 10'h000}, 8'h00, ~dqIn, 1'b1);
      idle(cyc(30));
   endtask

   // ****************************************
   // Power-up sequence
   // ****************************************
   // idle, then eight refreshes
   // run ends long before a refresh falls due
   task automatic init();
      idle(cyc(200000));
      repeat (8) begin
         issue(sdram_pkg::CMD_REFRESH, 12'h000, 8'h00, ~dqIn, 1'b1);
         idle(cyc(90));
      end
      open_row(2'h1);
      open_row(2'h2);
      idle(cyc(60));
      issue(sdram_pkg::CMD_PRECHARGE, 12'h000, 8'h00, ~dqIn, 1'b1);
      idle(cyc(30));
   endtask
endmodule

// file: sdram_module_command_timing_test.sv
// Purpose: Self-checking bench for the DRAM module command behaviour
// Assumes: Controller model keeps every command spacing
// Notes: Write buffer drains each idle cycle, so it never refuses here
`timescale 1ns/10ps
module sdram_module_command_timing_test;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] presenceIndex = 8'h00;
   logic cke;
   logic [3:0] command;
   logic [11:0] address;
   logic [1:0] bankSelect;
   logic [7:0] byteLaneMask;
   logic [63:0] dqIn;
   logic [63:0] dqOut;
   logic [7:0] dqOe;
   logic writeBufferReady;
   logic [7:0] presenceByte;
   logic [63:0] mem [16];
   int n_fail = 0;
   int samples_checked = 0;

   always #10 clock = ~clock;

   sdram_host_model ctl (.clock(clock), .cke(cke), .command(command),
      .address(address), .bankSelect(bankSelect),
      .byteLaneMask(byteLaneMask), .dqIn(dqIn));

   sdram_module_device DUT (.clock(clock), .arst_n(arst_n), .cke(cke),
      .chipSelect_n(command[3]), .rowStrobe_n(command[2]),
      .columnStrobe_n(command[1]), .writeEnable_n(command[0]),
      .address(address), .bankSelect(bankSelect),
      .byteLaneMask(byteLaneMask), .dqIn(dqIn), .dqOut(dqOut),
      .dqOe(dqOe), .writeBufferReady(writeBufferReady),
      .presenceIndex(presenceIndex), .presenceByte(presenceByte));

   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [63:0] exp,
         input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [63:0] wide(input logic [7:0] m);
      for (int b = 0; b < 8; b++) begin
         wide[b*8 +: 8] = {8{m[b]}};
      end
   endfunction

   // ****************************************
   // Transfers against the storage model
   // ****************************************
   task automatic wr(input int c, input int n, input bit sep,
         input bit msk);
      logic [63:0] d;
      logic [7:0] m;
      logic [3:0] cmd;
      for (int k = 0; k < n; k++) begin
         d = {$urandom, $urandom};
         m = msk ? 8'($urandom) : 8'h00;
         cmd = (k == 0 || sep) ? sdram_pkg::CMD_WRITE : 4'h7;
         for (int b = 0; b < 8; b++) begin
            if (!m[b]) begin
               mem[(c + k) % 16][b*8 +: 8] = d[b*8 +: 8];
            end
         end
         ctl.issue(cmd, 12'((c + k) % 16), m, d, 1'b1);
         check("ready", 64'h1, 64'(writeBufferReady));
      end
      ctl.idle(12);
   endtask

   task automatic rd(input int c, input int n, input bit sep,
         input int L);
      fork
         begin
            for (int k = 0; k < n; k++) begin
               ctl.issue((k == 0 || sep) ? sdram_pkg::CMD_READ : 4'h7,
                  12'((c + k) % 16), 8'h00, {$urandom, $urandom}, 1'b1);
            end
            ctl.idle(L + 3);
         end
         begin
            repeat (L + 1) @(negedge clock);
            for (int k = 0; k < n; k++) begin
               check("oe", 64'hff, 64'(dqOe));
               check("dq", mem[(c + k) % 16], dqOut);
               @(negedge clock);
            end
            check("oe after", 64'h0, 64'(dqOe));
         end
      join
   endtask

   task automatic mode(input logic [2:0] L, input logic [2:0] code);
      ctl.issue(sdram_pkg::CMD_MODE_SET, {5'h00, L, 1'b0, code}, 8'h00,
         64'h0, 1'b1);
      ctl.idle(1);
   endtask

   initial begin
      #400000;
      n_fail++;
      tally_and_finish();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int c;
      int n;
      int L;
      logic [7:0] sum;
      logic [7:0] m;
      void'($urandom(59));
      @(negedge clock);
      check("oe reset", 64'h0, 64'(dqOe));
      check("ready reset", 64'h1, 64'(writeBufferReady));
      check("presence reset", 64'h0, 64'(presenceByte));
      repeat (3) @(posedge clock);
      #1;
      arst_n = 1'b1;
      sum = 8'h00;
      for (int i = 0; i < 64; i++) begin
         presenceIndex = 8'(i);
         @(posedge clock);
         @(negedge clock);
         if (i < 63) begin
            sum = sum + presenceByte;
         end else begin
            check("checksum", 64'(sum), 64'(presenceByte));
         end
         @(posedge clock);
         #1;
      end
      ctl.init();
      ctl.open_row(2'h0);
      mode(3'h3, 3'h3);
      wr(0, 8, 1'b0, 1'b0);
      wr(8, 8, 1'b0, 1'b0);
      for (int i = 0; i < 8; i++) begin
         mode(3'(2 + i / 4), 3'(i % 4));
         c = $urandom % 16;
         n = (i % 4 == 0) ? 2 : 1 << (i % 4);
         wr(c, n, i % 4 == 0, 1'b1);
         rd(c, n, i % 4 == 0, 2 + i / 4);
      end
      for (int i = 0; i < 4; i++) begin
         L = 2 + i % 2;
         mode(3'(L), 3'h7);
         c = $urandom % 16;
         fork
            begin
               ctl.issue(sdram_pkg::CMD_READ, 12'(c), 8'h00, 64'h1, 1'b1);
               ctl.issue(4'h7, 12'h000, 8'h0f, 64'h2, 1'b1);
               ctl.idle(2);
               ctl.issue(i < 2 ? sdram_pkg::CMD_BURST_STOP :
                  sdram_pkg::CMD_PRECHARGE, 12'h000, 8'h00, 64'h3, 1'b1);
               ctl.idle(L + 3);
               if (i >= 2) begin
                  ctl.open_row(2'h0);
               end
            end
            begin
               repeat (L + 1) @(negedge clock);
               for (int k = 0; k < 4; k++) begin
                  m = (k == 3 - L) ? 8'hf0 : 8'hff;
                  check("oe mask", 64'(m), 64'(dqOe));
                  check("dq page", mem[(c + k) % 16] & wide(m),
                     dqOut & wide(m));
                  @(negedge clock);
               end
               check("oe end", 64'h0, 64'(dqOe));
            end
         join
      end
      mode(3'h3, 3'h0);
      c = $urandom % 16;
      fork
         begin
            ctl.issue(sdram_pkg::CMD_READ, 12'(c), 8'h00, 64'h4, 1'b0);
            ctl.idle(4);
            ctl.issue(4'h7, 12'h000, 8'h00, 64'h5, 1'b0);
            ctl.issue(sdram_pkg::CMD_READ, 12'(c), 8'h00, 64'h6, 1'b1);
            ctl.idle(8);
         end
         begin
            repeat (4) @(negedge clock);
            check("oe frozen", 64'h0, 64'(dqOe));
            @(negedge clock);
            check("oe late", 64'hff, 64'(dqOe));
            check("dq late", mem[c], dqOut);
            repeat (8) begin
               @(negedge clock);
               check("oe ignored", 64'h0, 64'(dqOe));
            end
         end
      join
      tally_and_finish();
   end
endmodule
